// *** common/vic_pkg.sv ***
package vic_pkg;
  localparam int NUM_CH      = 32;
  localparam int NUM_SLOTS   = 16;
  localparam int ADDR_W      = 8;
  // Register byte offsets
  localparam logic [7:0] REG_RAW_STAT   = 8'h00;
  localparam logic [7:0] REG_FAST_STAT  = 8'h04;
  localparam logic [7:0] REG_NORM_STAT  = 8'h08;
  localparam logic [7:0] REG_ENABLE     = 8'h0c;
  localparam logic [7:0] REG_CLASS_FAST = 8'h10;
  localparam logic [7:0] REG_SOFT_SET   = 8'h14;
  localparam logic [7:0] REG_SOFT_CLR   = 8'h18;
  localparam logic [7:0] REG_VECT_ADDR  = 8'h1c;
  localparam logic [7:0] REG_DEF_ADDR   = 8'h20;
  localparam logic [7:0] REG_EVT_STAT   = 8'h24;
  localparam logic [7:0] REG_EVT_CLR    = 8'h28;
  localparam logic [7:0] REG_EVT_EN     = 8'h2c;
  localparam logic [7:0] REG_SLOT_ADDR0 = 8'h40;
  localparam logic [7:0] REG_SLOT_CTL0  = 8'h80;
  // Slot control fields
  localparam int SLOT_CH_LSB = 0;
  localparam int SLOT_CH_W   = 5;
  localparam int SLOT_EN_BIT = 5;
  // Fixed channel map
  localparam int CH_WATCHDOG = 0;
  localparam int CH_SOFT     = 1;
  localparam int CH_DBG_RX   = 2;
  localparam int CH_DBG_TX   = 3;
  localparam int CH_TIMER0   = 4;
  localparam int CH_TIMER1   = 5;
  localparam int CH_SERIAL0  = 6;
  localparam int CH_SERIAL1  = 7;
  localparam int CH_PWM      = 8;
  localparam int CH_TWO_WIRE = 9;
  localparam int CH_SYNC0    = 10;
  localparam int CH_SYNC1    = 11;
  localparam int CH_SYNTH    = 12;
  localparam int CH_RTC      = 13;
  localparam int CH_EXT0     = 14;
  localparam int CH_CONV     = 18;
  localparam int CH_FILTER   = 19;
  localparam int CH_MSG1_TX  = 20;
  localparam int CH_MSG1_RX  = 21;
  localparam int CH_MSG2_TX  = 22;
  localparam int CH_MSG2_RX  = 23;
  localparam int CH_USED     = 24;
  // Event status bits
  localparam int EVT_FAST    = 0;
  localparam int EVT_NORM    = 1;
  localparam int EVT_W       = 2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// *** src/vic_ctrl.sv ***
// Functional notes
// - Each line classed fast, vectored slot, or non-vectored normal by software.
// - Fast requests outrank normal ones; all fast lines OR into one output.
// - Readable word shows which fast-classed enabled sources are requesting.
// - Sixteen slots, each mapped to any line; slot 0 highest, 15 lowest.
// - Vectored normal outranks non-vectored normal, which is lowest.
// - Normal output high whenever any vectored or non-vectored request is active.
// - Vector register gives winning slot address, else shared default address.
// - Readable word shows which normal-class lines are active.
// - Ch0 watchdog, ch1 software only, ch2/3 debug receive and transmit.
// - Ch4/5 timers, each merging four match and four capture flags.
// - Ch6/7 serial ports merge four flags; second adds modem status.
// - Ch8 pulse-width seven matches, ch9 two-wire, ch10/11 sync serial ports.
// - Ch12 synthesiser lock, ch13 clock increment and alarm merged.
// - Ch14 to 17 carry external inputs zero to three in order.
// - Ch18 converter, ch19 filter, ch20-23 message controllers tx then rx.
// - Ch24 to 31 have no source on this device and stay inactive.
module vic_ctrl #(
  parameter int NUM_SLOTS = vic_pkg::NUM_SLOTS
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_watchdog_req,
  input  wire logic        i_debug_comm_rx_req,
  input  wire logic        i_debug_comm_tx_req,
  input  wire logic [7:0]  i_timer0_flags,
  input  wire logic [7:0]  i_timer1_flags,
  input  wire logic [3:0]  i_serial0_flags,
  input  wire logic [4:0]  i_serial1_flags,
  input  wire logic [6:0]  i_pwm_match_flags,
  input  wire logic        i_two_wire_req,
  input  wire logic [1:0]  i_sync0_flags,
  input  wire logic [1:0]  i_sync1_flags,
  input  wire logic        i_synth_lock_flag,
  input  wire logic [1:0]  i_rtc_flags,
  input  wire logic [3:0]  i_ext_irq_in,
  input  wire logic        i_conv_done_req,
  input  wire logic        i_filter_req,
  input  wire logic [1:0]  i_msg1_req,
  input  wire logic [1:0]  i_msg2_req,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_fast_irq,
  output logic             o_norm_irq,
  output logic             o_evt_irq
);
  localparam int NC = vic_pkg::NUM_CH;

  logic [NC-1:0] line_d;
  logic [NC-1:0] raw_q;
  logic [NC-1:0] soft_q;
  logic [NC-1:0] enable_q;
  logic [NC-1:0] class_fast_q;
  logic [31:0]   def_addr_q;
  logic [31:0]   slot_addr_q [NUM_SLOTS];
  logic [vic_pkg::SLOT_CH_W-1:0] slot_ch_q [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] slot_en_q;
  logic [NC-1:0] fast_act;
  logic [NC-1:0] norm_act;
  logic [NUM_SLOTS-1:0] slot_hit;
  logic [31:0]   vect_d;
  logic [31:0]   vect_q;
  logic          fast_q;
  logic          norm_q;
  logic [vic_pkg::EVT_W-1:0] evt_stat_q;
  logic [vic_pkg::EVT_W-1:0] evt_en_q;
  logic          fast_prev_q;
  logic          norm_prev_q;

  // Merge each peripheral's own flags into its line; each message controller splits into a tx and an rx line
  always_comb begin
    line_d = '0;
    line_d[vic_pkg::CH_WATCHDOG] = i_watchdog_req;
    line_d[vic_pkg::CH_SOFT]     = 1'b0;
    line_d[vic_pkg::CH_DBG_RX]   = i_debug_comm_rx_req;
    line_d[vic_pkg::CH_DBG_TX]   = i_debug_comm_tx_req;
    line_d[vic_pkg::CH_TIMER0]   = |i_timer0_flags;
    line_d[vic_pkg::CH_TIMER1]   = |i_timer1_flags;
    line_d[vic_pkg::CH_SERIAL0]  = |i_serial0_flags;
    line_d[vic_pkg::CH_SERIAL1]  = |i_serial1_flags;
    line_d[vic_pkg::CH_PWM]      = |i_pwm_match_flags;
    line_d[vic_pkg::CH_TWO_WIRE] = i_two_wire_req;
    line_d[vic_pkg::CH_SYNC0]    = |i_sync0_flags;
    line_d[vic_pkg::CH_SYNC1]    = |i_sync1_flags;
    line_d[vic_pkg::CH_SYNTH]    = i_synth_lock_flag;
    line_d[vic_pkg::CH_RTC]      = |i_rtc_flags;
    line_d[vic_pkg::CH_EXT0 +: 4] = i_ext_irq_in;
    line_d[vic_pkg::CH_CONV]     = i_conv_done_req;
    line_d[vic_pkg::CH_FILTER]   = i_filter_req;
    line_d[vic_pkg::CH_MSG1_TX]  = i_msg1_req[0];
    line_d[vic_pkg::CH_MSG1_RX]  = i_msg1_req[1];
    line_d[vic_pkg::CH_MSG2_TX]  = i_msg2_req[0];
    line_d[vic_pkg::CH_MSG2_RX]  = i_msg2_req[1];
    // Channels 24 and up stay zero
  end

  // Registering the lines keeps outputs and vector in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      raw_q <= '0;
    end else begin
      raw_q <= (line_d | soft_q) & {{(NC-vic_pkg::CH_USED){1'b0}}, {vic_pkg::CH_USED{1'b1}}};
    end
  end

  // Software raise register, any channel but unused ones
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      soft_q <= '0;
    end else if (i_wr && i_addr == vic_pkg::REG_SOFT_SET) begin
      soft_q <= soft_q | i_wdata;
    end else if (i_wr && i_addr == vic_pkg::REG_SOFT_CLR) begin
      soft_q <= soft_q & ~i_wdata;
    end
  end

  // Configuration registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      enable_q     <= '0;
      class_fast_q <= '0;
      def_addr_q   <= vic_pkg::RESET_WORD;
      evt_en_q     <= '0;
    end else if (i_wr) begin
      if (i_addr == vic_pkg::REG_ENABLE)     enable_q     <= i_wdata;
      if (i_addr == vic_pkg::REG_CLASS_FAST) class_fast_q <= i_wdata;
      if (i_addr == vic_pkg::REG_DEF_ADDR)   def_addr_q   <= i_wdata;
      if (i_addr == vic_pkg::REG_EVT_EN)     evt_en_q     <= i_wdata[vic_pkg::EVT_W-1:0];
    end
  end

  // Slot address and control registers
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
        slot_addr_q[s] <= vic_pkg::RESET_WORD;
        slot_ch_q[s]   <= '0;
        slot_en_q[s]   <= 1'b0;
      end else if (i_wr) begin
        if (i_addr == vic_pkg::REG_SLOT_ADDR0 + 8'(4*s)) begin
          slot_addr_q[s] <= i_wdata;
        end
        if (i_addr == vic_pkg::REG_SLOT_CTL0 + 8'(4*s)) begin
          slot_ch_q[s] <= i_wdata[vic_pkg::SLOT_CH_LSB +: vic_pkg::SLOT_CH_W];
          slot_en_q[s] <= i_wdata[vic_pkg::SLOT_EN_BIT];
        end
      end
    end
    // A slot hits only for an enabled, normal-class line
    assign slot_hit[s] = slot_en_q[s] && norm_act[slot_ch_q[s]];
  end

  assign fast_act = raw_q & enable_q & class_fast_q;
  assign norm_act = raw_q & enable_q & ~class_fast_q;

  // Lowest slot index wins; no hit falls back to default
  always_comb begin
    vect_d = def_addr_q;
    for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
      if (slot_hit[s]) begin
        vect_d = slot_addr_q[s];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      fast_q <= 1'b0;
      norm_q <= 1'b0;
      vect_q <= vic_pkg::RESET_WORD;
    end else begin
      fast_q <= |fast_act;
      norm_q <= |norm_act;
      vect_q <= vect_d;
    end
  end

  assign o_fast_irq = fast_q;
  assign o_norm_irq = norm_q;

  // Rising-edge events on both outputs; set wins over clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      fast_prev_q <= 1'b0;
      norm_prev_q <= 1'b0;
      evt_stat_q  <= '0;
    end else begin
      fast_prev_q <= fast_q;
      norm_prev_q <= norm_q;
      evt_stat_q  <= (evt_stat_q
                      & ~((i_wr && i_addr == vic_pkg::REG_EVT_CLR) ?
                          i_wdata[vic_pkg::EVT_W-1:0] : {vic_pkg::EVT_W{1'b0}}))
                     | {norm_q & ~norm_prev_q, fast_q & ~fast_prev_q};
    end
  end

  assign o_evt_irq = |(evt_stat_q & evt_en_q);

  // Read port, data one cycle after strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= '0;
      unique case (i_addr)
        vic_pkg::REG_RAW_STAT:   o_rdata <= raw_q;
        vic_pkg::REG_FAST_STAT:  o_rdata <= fast_act;
        vic_pkg::REG_NORM_STAT:  o_rdata <= norm_act;
        vic_pkg::REG_ENABLE:     o_rdata <= enable_q;
        vic_pkg::REG_CLASS_FAST: o_rdata <= class_fast_q;
        vic_pkg::REG_SOFT_SET:   o_rdata <= soft_q;
        vic_pkg::REG_VECT_ADDR:  o_rdata <= vect_q;
        vic_pkg::REG_DEF_ADDR:   o_rdata <= def_addr_q;
        vic_pkg::REG_EVT_STAT:   o_rdata <= {30'h0, evt_stat_q};
        vic_pkg::REG_EVT_EN:     o_rdata <= {30'h0, evt_en_q};
        default: begin
          for (int s = 0; s < NUM_SLOTS; s++) begin
            if (i_addr == vic_pkg::REG_SLOT_ADDR0 + 8'(4*s)) o_rdata <= slot_addr_q[s];
            if (i_addr == vic_pkg::REG_SLOT_CTL0 + 8'(4*s)) begin
              o_rdata <= {26'h0, slot_en_q[s], slot_ch_q[s]};
            end
          end
        end
      endcase
    end
  end

  // Outputs and class split
  chk_fast_merge: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (|fast_act) |=> o_fast_irq)
    else $error("fast output missed active source");
  chk_fast_idle: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    !(|fast_act) |=> !o_fast_irq)
    else $error("fast output without source");
  chk_fast_stat: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (fast_act & ~(raw_q & class_fast_q)) == '0)
    else $error("fast status bad");
  chk_norm_out: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    ##1 (o_norm_irq == $past(|norm_act)))
    else $error("normal output wrong");
  chk_norm_class: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (norm_act & class_fast_q) == '0)
    else $error("fast line in normal set");

  // Vector selection
  chk_slot0_wins: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    slot_hit[0] |=> vect_q == $past(slot_addr_q[0]))
    else $error("slot 0 lost");
  chk_slot1_next: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    slot_hit[1] && !slot_hit[0] |=> vect_q == $past(slot_addr_q[1]))
    else $error("slot 1 lost");
  chk_vect_over_def: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    slot_hit[15] && slot_hit[14:0] == '0 |=> vect_q == $past(slot_addr_q[15]))
    else $error("default beat a vectored slot");
  chk_default_addr: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (slot_hit == '0) |=> vect_q == $past(def_addr_q))
    else $error("default addr");
  // Quiet normal output means no slot could have hit
  chk_out_vect: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    !o_norm_irq |-> vect_q == $past(def_addr_q))
    else $error("vector out of step");

  // Masking
  chk_unused_quiet: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    raw_q[NC-1:vic_pkg::CH_USED] == '0)
    else $error("unused channel active");
  chk_disabled_out: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (enable_q == '0) |=> !o_fast_irq && !o_norm_irq)
    else $error("disabled line fired");
  chk_masked_raw: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (raw_q & enable_q) == '0 |=> !o_fast_irq && !o_norm_irq)
    else $error("masked line reached an output");

  // Request map: each line reaches its raw bit one edge later
  chk_wdog_map: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_watchdog_req |=> raw_q[vic_pkg::CH_WATCHDOG])
    else $error("watchdog line lost");
  chk_soft_only: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    !soft_q[vic_pkg::CH_SOFT] |=> !raw_q[vic_pkg::CH_SOFT])
    else $error("software channel raised by hardware");
  chk_dbg_rx_map: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_debug_comm_rx_req |=> raw_q[vic_pkg::CH_DBG_RX])
    else $error("debug receive line lost");
  chk_dbg_tx_map: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_debug_comm_tx_req |=> raw_q[vic_pkg::CH_DBG_TX])
    else $error("debug transmit line lost");
  chk_timer_merge: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (|i_timer0_flags) |=> raw_q[vic_pkg::CH_TIMER0])
    else $error("timer merge");
  chk_timer1_merge: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (|i_timer1_flags) |=> raw_q[vic_pkg::CH_TIMER1])
    else $error("second timer merge");
  chk_serial0_merge: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (|i_serial0_flags) |=> raw_q[vic_pkg::CH_SERIAL0])
    else $error("first serial merge");
  chk_modem_merge: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_serial1_flags[4] |=> raw_q[vic_pkg::CH_SERIAL1])
    else $error("modem status not merged");
  chk_pwm_merge: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (|i_pwm_match_flags) |=> raw_q[vic_pkg::CH_PWM])
    else $error("pulse-width merge");
  chk_two_wire_map: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_two_wire_req |=> raw_q[vic_pkg::CH_TWO_WIRE])
    else $error("two-wire line lost");
  chk_sync_merge: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (|i_sync0_flags) |=> raw_q[vic_pkg::CH_SYNC0])
    else $error("first sync port merge");
  chk_sync1_merge: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (|i_sync1_flags) |=> raw_q[vic_pkg::CH_SYNC1])
    else $error("second sync port merge");
  chk_synth_map: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_synth_lock_flag |=> raw_q[vic_pkg::CH_SYNTH])
    else $error("lock line lost");
  chk_rtc_merge: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (|i_rtc_flags) |=> raw_q[vic_pkg::CH_RTC])
    else $error("clock flags not merged");
  chk_ext0_map: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_ext_irq_in[0] |=> raw_q[vic_pkg::CH_EXT0])
    else $error("first external input lost");
  chk_ext3_map: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_ext_irq_in[3] |=> raw_q[vic_pkg::CH_EXT0 + 3])
    else $error("last external input lost");
  chk_conv_map: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_conv_done_req |=> raw_q[vic_pkg::CH_CONV])
    else $error("converter line lost");
  chk_filter_map: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_filter_req |=> raw_q[vic_pkg::CH_FILTER])
    else $error("filter line lost");
  chk_msg_rx_map: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_msg1_req[1] |=> raw_q[vic_pkg::CH_MSG1_RX])
    else $error("first message receive lost");
  chk_msg2_tx_map: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_msg2_req[0] |=> raw_q[vic_pkg::CH_MSG2_TX])
    else $error("second message transmit lost");

  // Status reads return the state of the strobe cycle
  chk_fast_read: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_rd && i_addr == vic_pkg::REG_FAST_STAT |=> o_rdata == $past(fast_act))
    else $error("fast status read wrong");
  chk_norm_read: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_rd && i_addr == vic_pkg::REG_NORM_STAT |=> o_rdata == $past(norm_act))
    else $error("normal status read wrong");
  // Set must win over a same-cycle clear
  chk_evt_set_wins: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    fast_q && !fast_prev_q |=> evt_stat_q[vic_pkg::EVT_FAST])
    else $error("fast rise event lost");
endmodule

// *** tb/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [52:0] ONE = 53'h1;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [52:0] stim = '0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        fast_irq;
  logic        norm_irq;
  logic        evt_irq;
  logic [1:0]  core_mode;
  logic [31:0] got;
  int          miscompares = 0;
  int          n_tests = 0;
  int          sl[4] = '{0, 3, 5, 15};
  int          sc[4] = '{17, 15, 14, 16};

  vic_ctrl i_dut (
    .i_core_clk(clk), .i_rstn(rstn),
    .i_watchdog_req(stim[0]),
    .i_debug_comm_rx_req(stim[1]),
    .i_debug_comm_tx_req(stim[2]),
    .i_timer0_flags(stim[10:3]),
    .i_timer1_flags(stim[18:11]),
    .i_serial0_flags(stim[22:19]),
    .i_serial1_flags(stim[27:23]),
    .i_pwm_match_flags(stim[34:28]),
    .i_two_wire_req(stim[35]),
    .i_sync0_flags(stim[37:36]),
    .i_sync1_flags(stim[39:38]),
    .i_synth_lock_flag(stim[40]),
    .i_rtc_flags(stim[42:41]),
    .i_ext_irq_in(stim[46:43]),
    .i_conv_done_req(stim[47]),
    .i_filter_req(stim[48]),
    .i_msg1_req(stim[50:49]),
    .i_msg2_req(stim[52:51]),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_fast_irq(fast_irq),
    .o_norm_irq(norm_irq), .o_evt_irq(evt_irq)
  );

  vic_core_model i_core (
    .i_core_clk(clk), .i_rstn(rstn), .i_fast_irq(fast_irq),
    .i_norm_irq(norm_irq), .o_mode(core_mode)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
    chk(what, exp, got);
    @(posedge clk);
  endtask

  // Two edges: raw capture, then outputs and vector
  task automatic drive(input logic [52:0] s);
    stim <= s;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic case_chk(input logic [52:0] s, input logic f, input logic [31:0] vect,
                          input logic [31:0] nstat);
    drive(s);
    chk("irq_pair", {30'h0, f, nstat != 0}, {30'h0, fast_irq, norm_irq});
    rd_chk("vect", vic_pkg::REG_VECT_ADDR, vect);
    rd_chk("norm_stat", vic_pkg::REG_NORM_STAT, nstat);
    chk("core_mode", f ? 32'h2 : 32'(nstat != 0), {30'h0, core_mode});
  endtask

  function automatic int chan_of(input int b);
    if (b == 0) return 0;
    if (b < 3) return b + 1;
    if (b < 11) return 4;
    if (b < 19) return 5;
    if (b < 23) return 6;
    if (b < 28) return 7;
    if (b < 35) return 8;
    if (b < 40) return (b < 36) ? 9 : ((b < 38) ? 10 : 11);
    if (b < 43) return (b < 41) ? 12 : 13;
    return b - 29;
  endfunction

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk("irq_rst", 32'h0, {29'h0, evt_irq, fast_irq, norm_irq});
    rd_chk("enable_rst", vic_pkg::REG_ENABLE, vic_pkg::RESET_WORD);
    rd_chk("unmapped", 8'h30, 32'h0);
    // Every flag alone; exact match also proves ch24-31 stay quiet
    for (int b = 0; b < 53; b++) begin
      drive(ONE << b);
      chk("irq_off", 32'h0, {30'h0, fast_irq, norm_irq});
      rd_chk("raw_map", vic_pkg::REG_RAW_STAT, 32'h1 << chan_of(b));
    end
    drive('0);
    wr_reg(vic_pkg::REG_SOFT_SET, 32'h2);
    drive('0);
    rd_chk("soft_raw", vic_pkg::REG_RAW_STAT, 32'h2);
    wr_reg(vic_pkg::REG_SOFT_CLR, 32'h2);
    drive('0);
    rd_chk("soft_clr", vic_pkg::REG_RAW_STAT, 32'h0);
    wr_reg(vic_pkg::REG_ENABLE, 32'h0003f001);
    wr_reg(vic_pkg::REG_CLASS_FAST, 32'h00002001);
    wr_reg(vic_pkg::REG_DEF_ADDR, 32'h0000def0);
    for (int i = 0; i < 4; i++) begin
      wr_reg(vic_pkg::REG_SLOT_ADDR0 + 8'(4 * sl[i]), 32'(sl[i] + 32'ha000));
      wr_reg(vic_pkg::REG_SLOT_CTL0 + 8'(4 * sl[i]), 32'(sc[i] + 32));
    end
    case_chk(ONE << 43 | ONE << 44, 1'b0, 32'ha003, 32'h0000c000);
    case_chk(ONE << 43 | ONE << 40, 1'b0, 32'ha005, 32'h00005000);
    case_chk(ONE << 40, 1'b0, 32'h0000def0, 32'h00001000);
    case_chk(ONE << 45 | ONE << 46, 1'b0, 32'ha000, 32'h00030000);
    case_chk(ONE << 45, 1'b0, 32'ha00f, 32'h00010000);
    case_chk(ONE | ONE << 41 | ONE << 43, 1'b1, 32'ha005, 32'h00004000);
    rd_chk("fast_stat", vic_pkg::REG_FAST_STAT, 32'h00002001);
    wr_reg(vic_pkg::REG_ENABLE, 32'h0);
    case_chk(ONE | ONE << 41 | ONE << 43, 1'b0, 32'h0000def0, 32'h0);
    rd_chk("raw_dis", vic_pkg::REG_RAW_STAT, 32'h00006001);
    // Events latched earlier but still masked
    rd_chk("evt_stat", vic_pkg::REG_EVT_STAT, 32'h3);
    chk("evt_mask", 32'h0, {31'h0, evt_irq});
    wr_reg(vic_pkg::REG_EVT_EN, 32'h2);
    drive(stim);
    chk("evt_on", 32'h1, {31'h0, evt_irq});
    wr_reg(vic_pkg::REG_EVT_CLR, 32'h3);
    drive('0);
    rd_chk("evt_clr", vic_pkg::REG_EVT_STAT, 32'h0);
    chk("evt_off", 32'h0, {31'h0, evt_irq});
    final_report();
  end

  // Whole sequence needs under 2000 cycles
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule

// *** tb/vic_core_model.sv ***
module vic_core_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_fast_irq,
  input  wire logic       i_norm_irq,
  output logic      [1:0] o_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mode the core would enter: 2 fast, 1 normal, 0 none; fast masks normal
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_mode <= 2'h0;
    end else begin
      o_mode <= i_fast_irq ? 2'h2 : (i_norm_irq ? 2'h1 : 2'h0);
    end
  end
endmodule
